// *** shared/dclc_pkg.sv ***
// What this block does
// R1 - Receive clock activity flag reads 1 if any receive line clock since last read
// R2 - Transmit clock activity flag reads 1 if any transmit line clock since last read
// R3 - Writing 1 to receiver reset resets the receiver; bit self-clears
// R4 - Writing 1 to transmitter reset resets the transmitter; bit self-clears
// R5 - Local loop bit set routes outgoing stream back into receive input
// R6 - Remote loop bit set sends whole incoming stream out of transmitter
// R7 - Looped timing bit set clocks transmitter from recovered receive clock
// R8 - Activity crosses through synchronisers; a read clears only activity seen before it
package dclc_pkg;
   localparam logic [7:0] DCLC_ADDR_CTRL      = 8'h00;
   localparam logic [7:0] DCLC_CTRL_RESET     = 8'h00;
   localparam int         DCLC_BIT_RX_ACT     = 6;
   localparam int         DCLC_BIT_TX_ACT     = 5;
   localparam int         DCLC_BIT_RX_RST     = 4;
   localparam int         DCLC_BIT_TX_RST     = 3;
   localparam int         DCLC_BIT_LOCAL_LOOP = 2;
   localparam int         DCLC_BIT_REMOTE_LOOP = 1;
   localparam int         DCLC_BIT_LOOP_TIME  = 0;
   localparam int         DCLC_RST_PULSE_CYC  = 1;
endpackage : dclc_pkg

// *** hw/dclc_edge_det.sv ***
`timescale 1ns/10ps
// Synchronises one outside clock and pulses once per rising edge
module dclc_edge_det
   import dclc_pkg::*;
(
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic line_in,
   output logic      rise,
   output logic      level
);
   logic       sync1;
   logic       sync2;
   logic       sync3;
   logic [2:0] next_sh;

   // Shift chain: first stage feeds only the second
   always_comb begin
      next_sh = {sync2, sync1, line_in};
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
      end else begin
         sync1 <= next_sh[0];
         sync2 <= next_sh[1];
         sync3 <= next_sh[2];
      end
   end

   assign rise  = sync2 & ~sync3;   // [R8]
   assign level = sync2;
endmodule : dclc_edge_det

// *** hw/dclc_ctrl.sv ***
`timescale 1ns/10ps
// Line clock activity, soft resets and loop selection for the DS3 side
module dclc_ctrl
   import dclc_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       line_rx_clock,
   input  wire logic       line_tx_clock,
   input  wire logic       line_rx_data,
   input  wire logic       framer_tx_data,
   output logic            framer_rx_data,
   output logic            framer_rx_clock,
   output logic            line_tx_data,
   output logic            framer_tx_clock,
   output logic            rx_soft_reset,
   output logic            tx_soft_reset,
   output logic            local_line_loop_en,
   output logic            remote_line_loop_en,
   output logic            looped_timing_en
);
   ////////////////////////////////////////////////////////////////////////////
   // Line clock edge detection in the host clock domain
   logic rx_rise;
   logic tx_rise;
   logic rx_lvl;
   logic tx_lvl;

   dclc_edge_det u_rx_det (
      .clock   (clock),
      .rst_n   (rst_n),
      .line_in (line_rx_clock),
      .rise    (rx_rise),
      .level   (rx_lvl)
   );

   dclc_edge_det u_tx_det (
      .clock   (clock),
      .rst_n   (rst_n),
      .line_in (line_tx_clock),
      .rise    (tx_rise),
      .level   (tx_lvl)
   );

   // Data pins from outside also pass two flops
   logic [1:0] rxd_sync;
   logic [1:0] next_rxd_sync;

   always_comb begin
      next_rxd_sync = {rxd_sync[0], line_rx_data};
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rxd_sync <= 2'h0;
      end else begin
         rxd_sync <= next_rxd_sync;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control register and sticky activity flags
   logic rx_act;
   logic tx_act;
   logic rx_rst;
   logic tx_rst;
   logic loc_loop;
   logic rem_loop;
   logic loop_time;
   logic next_rx_act;
   logic next_tx_act;
   logic next_rx_rst;
   logic next_tx_rst;
   logic next_loc_loop;
   logic next_rem_loop;
   logic next_loop_time;
   logic hit;
   logic rd_ctrl;

   assign hit     = (reg_addr == DCLC_ADDR_CTRL);
   assign rd_ctrl = reg_rd & hit;

   always_comb begin
      next_rx_act    = rx_act;
      next_tx_act    = tx_act;
      next_rx_rst    = 1'b0;   // Self-clearing after one cycle
      next_tx_rst    = 1'b0;
      next_loc_loop  = loc_loop;
      next_rem_loop  = rem_loop;
      next_loop_time = loop_time;
      // Read clears what was captured; a new edge the same cycle wins
      if (rd_ctrl) begin
         next_rx_act = 1'b0;   // [R8]
         next_tx_act = 1'b0;   // [R8]
      end
      if (rx_rise) begin
         next_rx_act = 1'b1;   // [R1]
      end
      if (tx_rise) begin
         next_tx_act = 1'b1;   // [R2]
      end
      if (reg_wr && hit) begin
         next_rx_rst    = reg_wdata[DCLC_BIT_RX_RST];        // [R3]
         next_tx_rst    = reg_wdata[DCLC_BIT_TX_RST];        // [R4]
         next_loc_loop  = reg_wdata[DCLC_BIT_LOCAL_LOOP];    // [R5]
         next_rem_loop  = reg_wdata[DCLC_BIT_REMOTE_LOOP];   // [R6]
         next_loop_time = reg_wdata[DCLC_BIT_LOOP_TIME];     // [R7]
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rx_act    <= DCLC_CTRL_RESET[DCLC_BIT_RX_ACT];
         tx_act    <= DCLC_CTRL_RESET[DCLC_BIT_TX_ACT];
         rx_rst    <= DCLC_CTRL_RESET[DCLC_BIT_RX_RST];
         tx_rst    <= DCLC_CTRL_RESET[DCLC_BIT_TX_RST];
         loc_loop  <= DCLC_CTRL_RESET[DCLC_BIT_LOCAL_LOOP];
         rem_loop  <= DCLC_CTRL_RESET[DCLC_BIT_REMOTE_LOOP];
         loop_time <= DCLC_CTRL_RESET[DCLC_BIT_LOOP_TIME];
      end else begin
         rx_act    <= next_rx_act;
         tx_act    <= next_tx_act;
         rx_rst    <= next_rx_rst;
         tx_rst    <= next_tx_rst;
         loc_loop  <= next_loc_loop;
         rem_loop  <= next_rem_loop;
         loop_time <= next_loop_time;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data, valid one cycle after the read strobe
   logic [7:0] rdata;
   logic [7:0] next_rdata;

   always_comb begin
      next_rdata = 8'h00;
      if (rd_ctrl) begin
         next_rdata = {1'b0, rx_act, tx_act, rx_rst, tx_rst,
                       loc_loop, rem_loop, loop_time};   // [R1] [R2]
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rdata <= 8'h00;
      end else begin
         rdata <= next_rdata;
      end
   end

   assign reg_rdata = rdata;

   ////////////////////////////////////////////////////////////////////////////
   // Loop routing and clock selection, registered
   logic [4:0] route;
   logic [4:0] next_route;

   always_comb begin
      next_route[0] = loc_loop ? framer_tx_data : rxd_sync[1];   // [R5]
      next_route[1] = rem_loop ? rxd_sync[1] : framer_tx_data;   // [R6]
      next_route[2] = loop_time ? rx_lvl : tx_lvl;               // [R7]
      next_route[3] = loc_loop ? next_route[2] : rx_lvl;         // [R5]
      next_route[4] = 1'b0;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         route <= 5'h00;
      end else begin
         route <= next_route;
      end
   end

   assign framer_rx_data      = route[0];
   assign line_tx_data        = route[1];
   assign framer_tx_clock     = route[2];
   assign framer_rx_clock     = route[3];
   assign rx_soft_reset       = rx_rst;   // [R3]
   assign tx_soft_reset       = tx_rst;   // [R4]
   assign local_line_loop_en  = loc_loop;
   assign remote_line_loop_en = rem_loop;
   assign looped_timing_en    = loop_time;
endmodule : dclc_ctrl

// *** bench/dclc_line_model.sv ***
`timescale 1ns/10ps
// Line side: two free-phase line clocks that stand low outside a run, and a receive bit stream
module dclc_line_model (
   input  wire logic rx_run,
   input  wire logic tx_run,
   output logic      line_rx_clock,
   output logic      line_tx_clock,
   output logic      line_rx_data
);
   // Each clock finishes its high half before it stands still
   initial begin
      line_rx_clock = 1'b0;
      line_tx_clock = 1'b0;
      line_rx_data  = 1'b0;
   end
   initial begin
      #5.3;
      forever #40 if (rx_run || line_rx_clock) line_rx_clock = ~line_rx_clock;
   end
   initial begin
      #2.1;
      forever #40 if (tx_run || line_tx_clock) line_tx_clock = ~line_tx_clock;
   end
   // Data moves on the falling clock, and churns while no frame runs
   always @(negedge line_rx_clock) line_rx_data <= ~line_rx_data ^ line_tx_clock;
   always #11 if (!rx_run) line_rx_data <= ~line_rx_data;
endmodule : dclc_line_model

// *** bench/dclc_ctrl_props.sv ***
`timescale 1ns/10ps
// Checks on the control block ports
module dclc_ctrl_props
   import dclc_pkg::*;
(
   input wire logic       clock,
   input wire logic       rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       line_rx_clock,
   input wire logic       line_tx_clock,
   input wire logic       line_rx_data,
   input wire logic       framer_tx_data,
   input wire logic       framer_rx_data,
   input wire logic       framer_rx_clock,
   input wire logic       line_tx_data,
   input wire logic       framer_tx_clock,
   input wire logic       rx_soft_reset,
   input wire logic       tx_soft_reset,
   input wire logic       local_line_loop_en,
   input wire logic       remote_line_loop_en,
   input wire logic       looped_timing_en
);
   ////////////////////////////////////////
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // A write to the mapped register
   sequence wr_ctl;
      reg_wr && reg_addr == DCLC_ADDR_CTRL;
   endsequence
   rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("rdata not idle");
   rx_rst_a: assert property (wr_ctl ##0 reg_wdata[4] |=> rx_soft_reset)
      else $error("no rx reset");
   tx_rst_a: assert property (wr_ctl ##0 reg_wdata[3] |=> tx_soft_reset)
      else $error("no tx reset");
   rst_cause_a: assert property (rx_soft_reset || tx_soft_reset |-> $past(reg_wr))
      else $error("stray reset");
   loop_wr_a: assert property (wr_ctl |=> 3'($past(reg_wdata)) ==
      {local_line_loop_en, remote_line_loop_en, looped_timing_en}) else $error("loop bits");
   local_data_a: assert property ((local_line_loop_en && $stable(framer_tx_data))[*5]
      |-> framer_rx_data == framer_tx_data) else $error("local loop");
   remote_data_a: assert property ((remote_line_loop_en && $stable(line_rx_data))[*5]
      |-> line_tx_data == line_rx_data) else $error("remote loop");
   loop_time_a: assert property ((looped_timing_en && $stable(line_rx_clock))[*5]
      |-> framer_tx_clock == line_rx_clock) else $error("looped timing");
   // Without looped timing the transmitter keeps its own line clock
   own_tx_clock_a: assert property ((!looped_timing_en && $stable(line_tx_clock))[*5]
      |-> framer_tx_clock == line_tx_clock) else $error("own tx clock");
   // In local loop the receiver is clocked like the transmitter
   loop_rx_clock_a: assert property (local_line_loop_en[*2]
      |-> framer_rx_clock == framer_tx_clock) else $error("local loop clock");
   // Without remote loop the framer's bits reach the line
   own_tx_data_a: assert property ((!remote_line_loop_en && $stable(framer_tx_data))[*2]
      |-> line_tx_data == framer_tx_data) else $error("own tx data");
endmodule : dclc_ctrl_props
bind dclc_ctrl dclc_ctrl_props u_props (.*);

// *** bench/tb.sv ***
`timescale 1ns/10ps
module tb;
   logic       clock = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic       framer_tx_data = 1'b0, rx_run = 1'b0, tx_run = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic       line_rx_clock, line_tx_clock, line_rx_data, framer_rx_data, framer_rx_clock;
   logic       line_tx_data, framer_tx_clock, rx_soft_reset, tx_soft_reset;
   logic       local_line_loop_en, remote_line_loop_en, looped_timing_en;
   int         mismatches = 0, n_checks = 0;
   dclc_ctrl DUT (.*);
   dclc_line_model u_line (.*);
   // Compare and report
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s exp %h got %h", what, exp, got);
      end
   endtask : chk
   // One-cycle register write and read
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clock);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 chk("rdata", exp, reg_rdata);
   endtask : rd
   // Run the chosen line clocks for a while, then let them stand
   task automatic run(input logic r, input logic t, input int ns);
      {rx_run, tx_run} <= {r, t};
      #ns;
      {rx_run, tx_run} <= 2'b00;
      #200;
   endtask : run
   task automatic t_activity;
      rd(8'h00, 8'h00);
      for (int i = 0; i < 2; i++) begin
         run(i == 0, i == 1, 400);
         rd(8'h00, 8'h40 >> i);
         rd(8'h00, 8'h00);
      end
   endtask : t_activity
   task automatic t_soft_reset;
      wr(8'h00, 8'h18);
      chk("rst", 8'h03, {6'h00, rx_soft_reset, tx_soft_reset});
      @(posedge clock);
      #1 chk("rst", 8'h00, {6'h00, rx_soft_reset, tx_soft_reset});
      rd(8'h00, 8'h00);
   endtask : t_soft_reset
   task automatic t_loops;
      for (int i = 0; i < 3; i++) begin
         wr(8'h00, 8'h01 << i);
         chk("loop", 8'h01 << i,
             {5'h00, local_line_loop_en, remote_line_loop_en, looped_timing_en});
         run(1'b1, 1'b1, 800);
         if (i > 0) rd(8'h00, 8'h60 | (8'h01 << i));
      end
   endtask : t_loops
   task automatic t_unmapped;
      wr(8'h00, 8'h00);
      wr(8'h01, 8'h07);
      rd(8'h01, 8'h00);
      rd(8'h00, 8'h00);
   endtask : t_unmapped
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out
   ////////////////////////////////////////
   always #4 clock = ~clock;
   // Framer bits change every seven cycles
   always begin
      repeat (7) @(posedge clock);
      framer_tx_data <= ~framer_tx_data;
   end
   initial begin
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      t_activity;
      t_soft_reset;
      t_loops;
      t_unmapped;
      close_out;
   end
   // Watchdog well past the expected few microseconds
   initial begin
      #100000;
      mismatches++;
      close_out;
   end
endmodule : tb
